// ### cirs_pkg.sv
// cirs_pkg: constants and state types shared by both ends of the codec
// two-wire control link; assumes a single 10 MHz core clock on each end.
package cirs_pkg;
  localparam int CORE_CLK_HZ = 10_000_000;
  // standard and fast mode ceiling; the host never runs faster than this
  localparam int SCL_MAX_HZ = 1_000_000;
  // high-speed ceiling, listed for reference only
  localparam int SCL_HS_MAX_HZ = 3_400_000;
  // quarter bit period in core cycles, rounded up so the bus stays under the ceiling
  localparam int QUARTER_CYC = (CORE_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam logic [1:0] ADDR_SEL_RST = 2'h2;
  localparam logic WMODE_RST = 1'b0;
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h18;
  localparam logic [7:0] MAP_LAST = 8'hcd;
  localparam int MAP_DEPTH = int'(MAP_LAST) + 1;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] READ_MISS = 8'h00;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACKDONE = 4'h9;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_DEVADR = 3'b001,
    DEV_REGADR = 3'b010,
    DEV_WRDATA = 3'b011,
    DEV_RDDATA = 3'b100
  } cirs_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_START = 2'b01,
    HOST_BYTE = 2'b10,
    HOST_STOP = 2'b11
  } cirs_host_state_t;
endpackage : cirs_pkg

// ### cirs_if.sv
// cirs_if: the two open-drain wires between host and codec control port.
// assumes external pull-ups; a wire is low when any enabled driver pulls it.
`timescale 1ns/1ps
interface cirs_if;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  wire scl;
  wire sda;

  // released wires float high through the pull-ups
  assign scl = hostSclOe ? hostSclOut : 1'b1;
  assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

  modport host (output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe,
    input scl, input sda);
  modport dev (output devSdaOut, output devSdaOe, input scl, input sda);
endinterface : cirs_if

// ### cirs_slave.sv
// cirs_slave: codec end of the two-wire control port, holding the register map.
// assumes scl/sda come from another domain and are resynchronised here; the
// host owns the clock and all start/stop conditions.
`timescale 1ns/1ps
module cirs_slave (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic ifEnable, // control port enabled
  input wire logic [1:0] addrSel, // slave address select
  input wire logic writeMode, // 0 page mode, 1 repeat mode
  output logic wrStrobe_r, // one-cycle pulse per stored byte
  output logic [7:0] wrAddr_r, // register address of that byte
  output logic [7:0] wrData_r, // value written
  output logic busy_r, // a message addressed to us is open
  cirs_if.dev bus // two-wire link
);
  logic sclS1_r;
  logic sclS2_r;
  logic sclD_r;
  logic sdaS1_r;
  logic sdaS2_r;
  logic sdaD_r;
  logic sdaOe_r;
  logic sdaOut_r;
  cirs_pkg::cirs_dev_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rxShift_r;
  logic [7:0] txShift_r;
  logic [7:0] ptr_r;
  logic readDir_r;
  logic firstData_r;
  logic hostAck_r;
  logic [1:0] selAct_r;
  logic modeAct_r;
  logic [7:0] regMap [0:cirs_pkg::MAP_DEPTH-1];

  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire [6:0] ownAddr;
  wire addrHit;
  wire [7:0] ptrInc;
  wire [7:0] rdPtr;
  wire [7:0] wrPtr;
  wire [7:0] loadAddr;
  wire [7:0] loadByte;

  // edges are taken only from the second synchroniser stage onward
  assign sclRise = sclS2_r & ~sclD_r;
  assign sclFall = ~sclS2_r & sclD_r;
  assign startCond = sclS2_r & sclD_r & sdaD_r & ~sdaS2_r;
  assign stopCond = sclS2_r & sclD_r & ~sdaD_r & sdaS2_r;
  assign ownAddr = cirs_pkg::SLAVE_ADDR_BASE + {5'h00, selAct_r};
  assign addrHit = rxShift_r[7:1] == ownAddr;
  assign ptrInc = ptr_r + 8'h01;
  assign rdPtr = modeAct_r ? ptr_r : ptrInc;
  assign wrPtr = (!modeAct_r && !firstData_r) ? ptrInc : ptr_r;
  assign loadAddr = (state_r == cirs_pkg::DEV_RDDATA) ? rdPtr : ptr_r;
  assign loadByte = (loadAddr <= cirs_pkg::MAP_LAST) ? regMap[loadAddr]
    : cirs_pkg::READ_MISS;

  // the codec only ever pulls sda low and has no scl driver at all
  assign bus.devSdaOe = sdaOe_r;
  assign bus.devSdaOut = sdaOut_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sclD_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclS1_r <= bus.scl;
      sclS2_r <= sclS1_r;
      sclD_r <= sclS2_r;
      sdaS1_r <= bus.sda;
      sdaS2_r <= sdaS1_r;
      sdaD_r <= sdaS2_r;
    end
  end

  // open-drain output level is always low; only the enable moves
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sdaOut_r <= 1'b0;
    end
  end

  // the map has no other access path: every register lives here
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < cirs_pkg::MAP_DEPTH; i++) begin
        regMap[i] <= cirs_pkg::REG_RST;
      end
    end else if (wrStrobe_r && wrAddr_r <= cirs_pkg::MAP_LAST) begin
      regMap[wrAddr_r] <= wrData_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= cirs_pkg::DEV_IDLE;
      bitCnt_r <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      ptr_r <= 8'h00;
      readDir_r <= 1'b0;
      firstData_r <= 1'b0;
      hostAck_r <= 1'b0;
      selAct_r <= cirs_pkg::ADDR_SEL_RST;
      modeAct_r <= cirs_pkg::WMODE_RST;
      sdaOe_r <= 1'b0;
      wrStrobe_r <= 1'b0;
      wrAddr_r <= 8'h00;
      wrData_r <= 8'h00;
      busy_r <= 1'b0;
    end else begin
      wrStrobe_r <= 1'b0;
      busy_r <= (state_r != cirs_pkg::DEV_IDLE) && (state_r != cirs_pkg::DEV_DEVADR);
      if (!ifEnable) begin
        state_r <= cirs_pkg::DEV_IDLE;
        sdaOe_r <= 1'b0;
      end else if (startCond) begin
        // a start, first or repeated, always restarts address matching
        state_r <= cirs_pkg::DEV_DEVADR;
        bitCnt_r <= 4'h0;
        sdaOe_r <= 1'b0;
        selAct_r <= addrSel;
        modeAct_r <= writeMode;
      end else if (stopCond) begin
        state_r <= cirs_pkg::DEV_IDLE;
        sdaOe_r <= 1'b0;
      end else if (state_r != cirs_pkg::DEV_IDLE) begin
        if (sclRise) begin
          if (bitCnt_r < cirs_pkg::BIT_ACK) begin
            rxShift_r <= {rxShift_r[6:0], sdaS2_r};
          end else begin
            hostAck_r <= ~sdaS2_r;
          end
          bitCnt_r <= bitCnt_r + 4'h1;
        end else if (sclFall) begin
          if (bitCnt_r == cirs_pkg::BIT_ACK) begin
            // eighth bit done: claim the ack slot when receiving
            case (state_r)
              cirs_pkg::DEV_DEVADR: begin
                if (addrHit) begin
                  sdaOe_r <= 1'b1;
                  readDir_r <= rxShift_r[0];
                end else begin
                  state_r <= cirs_pkg::DEV_IDLE;
                end
              end
              cirs_pkg::DEV_REGADR: begin
                ptr_r <= rxShift_r;
                firstData_r <= 1'b1;
                sdaOe_r <= 1'b1;
              end
              cirs_pkg::DEV_WRDATA: begin
                wrStrobe_r <= 1'b1;
                wrAddr_r <= wrPtr;
                wrData_r <= rxShift_r;
                ptr_r <= wrPtr;
                firstData_r <= 1'b0;
                sdaOe_r <= 1'b1;
              end
              default: begin
                sdaOe_r <= 1'b0;
              end
            endcase
          end else if (bitCnt_r == cirs_pkg::BIT_ACKDONE) begin
            bitCnt_r <= 4'h0;
            sdaOe_r <= 1'b0;
            case (state_r)
              cirs_pkg::DEV_DEVADR: begin
                if (readDir_r) begin
                  state_r <= cirs_pkg::DEV_RDDATA;
                  txShift_r <= loadByte;
                  sdaOe_r <= ~loadByte[7];
                end else begin
                  state_r <= cirs_pkg::DEV_REGADR;
                end
              end
              cirs_pkg::DEV_REGADR: begin
                state_r <= cirs_pkg::DEV_WRDATA;
              end
              cirs_pkg::DEV_WRDATA: begin
                // repeat mode pairs every data byte with its own address byte
                if (modeAct_r) begin
                  state_r <= cirs_pkg::DEV_REGADR;
                end
              end
              cirs_pkg::DEV_RDDATA: begin
                if (hostAck_r) begin
                  ptr_r <= rdPtr;
                  txShift_r <= loadByte;
                  sdaOe_r <= ~loadByte[7];
                end else begin
                  state_r <= cirs_pkg::DEV_IDLE;
                end
              end
              default: begin
                state_r <= cirs_pkg::DEV_IDLE;
              end
            endcase
          end else if (state_r == cirs_pkg::DEV_RDDATA && bitCnt_r != 4'h0) begin
            // next data bit goes out only while scl is low
            txShift_r <= {txShift_r[6:0], 1'b0};
            sdaOe_r <= ~txShift_r[6];
          end
        end
      end
    end
  end
  // limitation: at a 10 MHz core clock only bus rates well under
  // the high-speed ceiling are oversampled reliably
endmodule : cirs_slave

// ### cirs_master.sv
// cirs_master: host end of the two-wire control link; one register write, or
// one register read by address write, repeated start and single nak'd byte.
// assumes the codec never stretches scl, so scl is not read back.
`timescale 1ns/1ps
module cirs_master (
  input wire logic core_clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic cmdValid, // start a transfer, taken when idle
  input wire logic cmdRead, // 1 read, 0 write
  input wire logic [6:0] cmdDev, // slave address
  input wire logic [7:0] cmdReg, // register address
  input wire logic [7:0] cmdData, // write data
  output logic busy_r, // transfer in progress
  output logic done_r, // one-cycle pulse at the end
  output logic ackErr_r, // slave did not acknowledge
  output logic [7:0] rdData_r, // byte read back
  cirs_if.host bus // two-wire link
);
  logic sdaS1_r;
  logic sdaS2_r;
  cirs_pkg::cirs_host_state_t state_r;
  logic [3:0] qCnt_r;
  logic [1:0] phase_r;
  logic [3:0] bitIdx_r;
  logic [1:0] byteIdx_r;
  logic [7:0] txShift_r;
  logic [7:0] rxShift_r;
  logic sclLow_r;
  logic sdaLow_r;
  logic rdCmd_r;
  logic [6:0] dev_r;
  logic [7:0] reg_r;
  logic [7:0] data_r;

  wire tick;
  wire rxByte;
  wire lastBit;
  wire [7:0] byteVal;
  wire [7:0] txSrc;
  wire nak;
  wire toRestart;
  wire toStop;

  assign tick = qCnt_r == 4'(cirs_pkg::QUARTER_CYC - 1);
  assign rxByte = rdCmd_r && byteIdx_r == 2'h3;
  assign lastBit = bitIdx_r == cirs_pkg::BIT_ACK;
  // byte order of a message: address, register, then data or re-address
  assign byteVal = (byteIdx_r == 2'h0) ? {dev_r, 1'b0}
    : (byteIdx_r == 2'h1) ? reg_r
    : (byteIdx_r == 2'h2 && rdCmd_r) ? {dev_r, 1'b1}
    : (byteIdx_r == 2'h2) ? data_r : 8'hff;
  assign txSrc = (bitIdx_r == 4'h0) ? byteVal : txShift_r;
  assign nak = !rxByte && sdaS2_r;
  assign toRestart = rdCmd_r && byteIdx_r == 2'h1;
  assign toStop = nak || rxByte || (!rdCmd_r && byteIdx_r == 2'h2);

  // both wires are open-drain here; high-speed push-pull clocking is not offered
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSclOe = sclLow_r;
  assign bus.hostSdaOe = sdaLow_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
    end else begin
      sdaS1_r <= bus.sda;
      sdaS2_r <= sdaS1_r;
    end
  end

  // divider runs only inside a message so every frame starts aligned
  always_ff @(posedge core_clk) begin
    if (reset || state_r == cirs_pkg::HOST_IDLE) begin
      qCnt_r <= 4'h0;
      phase_r <= 2'h0;
    end else begin
      qCnt_r <= tick ? 4'h0 : qCnt_r + 4'h1;
      phase_r <= tick ? phase_r + 2'h1 : phase_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= cirs_pkg::HOST_IDLE;
      bitIdx_r <= 4'h0;
      byteIdx_r <= 2'h0;
      txShift_r <= 8'h00;
      rxShift_r <= 8'h00;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      rdCmd_r <= 1'b0;
      dev_r <= 7'h00;
      reg_r <= 8'h00;
      data_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ackErr_r <= 1'b0;
      rdData_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        cirs_pkg::HOST_IDLE: begin
          if (cmdValid) begin
            state_r <= cirs_pkg::HOST_START;
            busy_r <= 1'b1;
            ackErr_r <= 1'b0;
            rdCmd_r <= cmdRead;
            dev_r <= cmdDev;
            reg_r <= cmdReg;
            data_r <= cmdData;
            byteIdx_r <= 2'h0;
            bitIdx_r <= 4'h0;
          end
        end
        cirs_pkg::HOST_START: begin
          // release data, then clock, then pull data low while clock is high
          if (tick) begin
            case (phase_r)
              2'h0: sdaLow_r <= 1'b0;
              2'h1: sclLow_r <= 1'b0;
              2'h2: sdaLow_r <= 1'b1;
              default: begin
                sclLow_r <= 1'b1;
                state_r <= cirs_pkg::HOST_BYTE;
              end
            endcase
          end
        end
        cirs_pkg::HOST_BYTE: begin
          if (tick) begin
            case (phase_r)
              2'h0: begin
                // data moves a quarter after the fall, clear of the high phase;
                // the ack slot and every read bit are left released
                sdaLow_r <= !lastBit && !rxByte && !txSrc[7];
                if (!lastBit) begin
                  txShift_r <= {txSrc[6:0], 1'b0};
                end
              end
              2'h1, 2'h2: sclLow_r <= 1'b0;
              default: begin
                sclLow_r <= 1'b1;
                if (!lastBit) begin
                  rxShift_r <= {rxShift_r[6:0], sdaS2_r};
                  bitIdx_r <= bitIdx_r + 4'h1;
                end else begin
                  bitIdx_r <= 4'h0;
                  byteIdx_r <= byteIdx_r + 2'h1;
                  ackErr_r <= ackErr_r | nak;
                  if (rxByte) begin
                    rdData_r <= rxShift_r;
                  end
                  if (toStop) begin
                    state_r <= cirs_pkg::HOST_STOP;
                  end else if (toRestart) begin
                    state_r <= cirs_pkg::HOST_START;
                  end
                end
              end
            endcase
          end
        end
        cirs_pkg::HOST_STOP: begin
          if (tick) begin
            case (phase_r)
              2'h0: sdaLow_r <= 1'b1;
              2'h1: sclLow_r <= 1'b0;
              2'h2: sdaLow_r <= 1'b0;
              default: begin
                state_r <= cirs_pkg::HOST_IDLE;
                busy_r <= 1'b0;
                done_r <= 1'b1;
              end
            endcase
          end
        end
        default: state_r <= cirs_pkg::HOST_IDLE;
      endcase
    end
  end
endmodule : cirs_master

// ### cirs_props.sv
// cirs_props: checks on the two wires between host and codec ends.
// assumes it sits beside the one interface that joins both ends.
`timescale 1ns/1ps
module cirs_props (
  input wire logic core_clk, // core clock
  input wire logic reset, // sync reset
  input wire logic hostSclOut, // host clock level
  input wire logic hostSclOe, // host clock enable
  input wire logic hostSdaOut, // host data level
  input wire logic hostSdaOe, // host data enable
  input wire logic devSdaOut, // codec data level
  input wire logic devSdaOe, // codec data enable
  input wire logic scl, // resolved clock
  input wire logic sda // resolved data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic sclD_r, sdaD_r;
  logic [3:0] edge_r, per_r, low_r;
  wire isStart = scl && sclD_r && sdaD_r && !sda;
  wire isStop = scl && sclD_r && !sdaD_r && sda;
  wire sclRise = scl && !sclD_r;
  // counters saturate so a long idle never wraps into a false count
  wire [3:0] edge_nxt = isStart ? 4'h0 : (sclRise && edge_r != 4'hf) ? edge_r + 4'h1 : edge_r;
  wire [3:0] per_nxt = sclRise ? 4'h1 : (per_r == 4'hf) ? per_r : per_r + 4'h1;
  wire [3:0] low_nxt = scl ? 4'h0 : (low_r == 4'hf) ? low_r : low_r + 4'h1;
  always_ff @(posedge core_clk) begin
    sclD_r <= reset ? 1'b1 : scl;
    sdaD_r <= reset ? 1'b1 : sda;
    edge_r <= reset ? 4'hf : edge_nxt;
    per_r <= reset ? 4'hf : per_nxt;
    low_r <= reset ? 4'h0 : low_nxt;
  end
  AST_DEV_OPEN_DRAIN: assert property (devSdaOe |-> !devSdaOut)
    else $error("codec drives data high");
  AST_HOST_OPEN_DRAIN: assert property (hostSdaOe |-> !hostSdaOut)
    else $error("host drives data high");
  AST_START_BY_HOST: assert property (isStart |-> hostSdaOe && !$past(devSdaOe))
    else $error("start not made by host");
  AST_DEV_STABLE_HIGH: assert property (scl && sclD_r |-> $stable(devSdaOe))
    else $error("codec data moved while clock high");
  // the count lags the rise by a cycle, so the ninth rise is judged by its next value
  AST_ADDR_SILENT: assert property (scl && edge_nxt <= 4'h8 |-> !devSdaOe)
    else $error("codec drove during address bits");
  AST_STOP_RELEASE: assert property (isStop |=> !devSdaOe [*4])
    else $error("codec held data after stop");
  AST_SCL_RATE: assert property (sclRise && per_r != 4'hf |-> per_r >= 4'ha)
    else $error("clock faster than 1 MHz");
  AST_SCL_LOW_BOUND: assert property (!scl |-> low_r != 4'hf)
    else $error("clock held low too long");
  cover property (isStart);
  cover property (isStop);
  cover property (devSdaOe && sclRise);
endmodule : cirs_props

// ### tb.sv
// tb: host end and codec end joined by one link; host commands in,
// codec stores and read data out. assumes 10 MHz core clock.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic [6:0] cmdDev = 7'h00;
  logic [7:0] cmdReg = 8'h00;
  logic [7:0] cmdData = 8'h00;
  logic ifEnable = 1'b1;
  logic writeMode = 1'b0;
  logic [1:0] addrSel = 2'h2;
  logic mBusy, done, ackErr, wrStrobe, sBusy, sclD, sdaD;
  logic [7:0] rdData, wrAddr, wrData, lastA, lastD, firstByte;
  int error_cnt = 0;
  int total_checks = 0;
  int strobeCnt = 0;
  int bitN = 8;
  cirs_if bus ();
  cirs_master u_cirs_master (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdDev(cmdDev), .cmdReg(cmdReg), .cmdData(cmdData), .busy_r(mBusy),
    .done_r(done), .ackErr_r(ackErr), .rdData_r(rdData), .bus(bus));
  cirs_slave u_cirs_slave (.core_clk(core_clk), .reset(reset), .ifEnable(ifEnable),
    .addrSel(addrSel), .writeMode(writeMode), .wrStrobe_r(wrStrobe), .wrAddr_r(wrAddr),
    .wrData_r(wrData), .busy_r(sBusy), .bus(bus));
  cirs_props u_cirs_props (.core_clk(core_clk), .reset(reset), .hostSclOut(bus.hostSclOut),
    .hostSclOe(bus.hostSclOe), .hostSdaOut(bus.hostSdaOut), .hostSdaOe(bus.hostSdaOe),
    .devSdaOut(bus.devSdaOut), .devSdaOe(bus.devSdaOe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // wire monitor: stores and the first byte after each start
  always @(posedge core_clk) begin
    if (wrStrobe === 1'b1) begin
      strobeCnt++;
      lastA = wrAddr;
      lastD = wrData;
    end
    if (bus.scl && sclD && sdaD && !bus.sda) bitN = 0;
    else if (bus.scl && !sclD && bitN < 8) begin
      firstByte = {firstByte[6:0], bus.sda};
      bitN++;
    end
    sclD = bus.scl;
    sdaD = bus.sda;
  end
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
      input logic [7:0] dt);
    int n;
    n = 0;
    @(posedge core_clk) #1;
    {cmdRead, cmdDev, cmdReg, cmdData, cmdValid} = {rd, dev, rg, dt, 1'b1};
    @(posedge core_clk) #1;
    cmdValid = 1'b0;
    do begin
      @(posedge core_clk) #1;
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      close_out();
    end
  endtask : xfer
  task automatic sc_addr();
    for (int s = 0; s < 4; s++) begin
      addrSel = 2'(s);
      xfer(1'b0, 7'h18 + 7'(s), 8'h10 + 8'(s), 8'h5a ^ 8'(s));
      chk({7'h00, ackErr}, 8'h00);
      chk(lastA, 8'h10 + 8'(s));
      chk(lastD, 8'h5a ^ 8'(s));
      xfer(1'b1, 7'h18 + 7'(s), 8'h10 + 8'(s), 8'h00);
      chk(rdData, 8'h5a ^ 8'(s));
    end
  endtask : sc_addr
  task automatic sc_refuse();
    int n0;
    n0 = strobeCnt;
    addrSel = 2'h2;
    xfer(1'b0, 7'h1b, 8'h11, 8'h77);
    chk({7'h00, ackErr}, 8'h01);
    ifEnable = 1'b0;
    xfer(1'b0, 7'h1a, 8'h11, 8'h77);
    chk({7'h00, ackErr}, 8'h01);
    ifEnable = 1'b1;
    chk(8'(strobeCnt - n0), 8'h00);
    xfer(1'b1, 7'h1a, 8'hf0, 8'h00);
    chk(rdData, 8'h00);
  endtask : sc_refuse
  task automatic sc_mode_sel();
    writeMode = 1'b1;
    fork
      xfer(1'b0, 7'h1a, 8'h20, 8'hc3);
      begin
        repeat (60) @(posedge core_clk);
        #1 addrSel = 2'h0;
      end
    join
    chk({7'h00, ackErr}, 8'h00);
    chk(firstByte, 8'h34);
    chk({6'h00, bus.scl, bus.sda}, 8'h03);
    xfer(1'b1, 7'h18, 8'h20, 8'h00);
    chk(rdData, 8'hc3);
  endtask : sc_mode_sel
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset = 1'b0;
    chk({6'h00, mBusy, sBusy}, 8'h00);
    sc_addr();
    sc_refuse();
    sc_mode_sel();
    close_out();
  end
endmodule : tb
